// File: src/operator_panel_controller.sv
// operator panel: lamps, display, keys, knob and apb registers
`timescale 1ns/100ps
`default_nettype none
`include "panel_cfg.svh"

// Operation
// - display shows frequencies, monitors, fault data
// - run lamp lit only while running
// - direction lamp lit for reverse rotation
// - source lamp dark for panel commands
// - source lamp steady terminal, blinking communication
// - fault lamp steady in torque mode
// - fault lamp blinks slowly while auto-tuning
// - fault lamp blinks fast on fault
// - knob rotation raises or lowers value
// - menu key enters or leaves level one
// - confirm descends levels, commits at deepest
// - multi key action set by configuration
// - shift cycles monitored quantity at the monitor level only
// - shift selects digit while editing
// - increment key raises value one step
// - decrement key lowers value one step
// - run key works only from panel source
// - stop key stops a running drive
// - stop key resets a faulted drive
// - stop and reset gated by configuration
// - source select: panel, terminal, communication
module operator_panel_controller #(
  parameter int DATA_W    = 16,
  parameter int CODE_W    = 8,
  parameter int MON_N     = 8,
  parameter int SLOW_HALF = `CLK_HZ / (2 * `SLOW_BLINK_HZ),
  parameter int FAST_HALF = `CLK_HZ / (2 * `FAST_BLINK_HZ),
  parameter int DEB_CYC   = `CLK_HZ / 1000 * `DEBOUNCE_MS
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic [`KEY_N-1:0] key_raw,
  input  wire logic              enc_a,
  input  wire logic              enc_b,
  input  wire logic              drive_running,
  input  wire logic              drive_reverse,
  input  wire logic              drive_torque_mode,
  input  wire logic              drive_tuning,
  input  wire logic              drive_fault,
  input  wire logic [DATA_W-1:0] set_freq,
  input  wire logic [DATA_W-1:0] out_freq,
  input  wire logic [DATA_W-1:0] monitor_value,
  input  wire logic [DATA_W-1:0] fault_code,
  input  wire logic [DATA_W-1:0] param_value,
  output var  logic [DATA_W-1:0] display_value,
  output var  logic [3:0]        monitor_sel,
  output var  logic              run_lamp,
  output var  logic              direction_lamp,
  output var  logic              source_lamp,
  output var  logic              tuning_torque_fault_lamp,
  output var  logic [CODE_W-1:0] param_code,
  output var  logic [DATA_W-1:0] param_wr_data,
  output var  logic              param_wr,
  output var  logic              run_cmd,
  output var  logic              stop_cmd,
  output var  logic              fault_reset,
  output var  logic              freq_up,
  output var  logic              freq_down,
  output var  logic              dir_toggle
);

  localparam int DIGITS = DATA_W / 4;

  if (DATA_W < 8 || DATA_W > 32 || DATA_W % 4 != 0 || CODE_W < 1 || CODE_W > 16 ||
      MON_N < 3 || MON_N > 16 || SLOW_HALF <= FAST_HALF || FAST_HALF < 1 || DEB_CYC < 1)
  begin : g_bad_params
    $error("operator_panel_controller: unsupported parameter values");
  end

  // step for the selected digit, one nibble per digit
  function automatic logic [DATA_W-1:0] digit_step(input logic [3:0] d);
    digit_step = DATA_W'(1) << (4 * d);
  endfunction : digit_step

  // *************************************************************
  // apb slave
  // *************************************************************
  logic [5:0]  ctrl_q;
  logic        local_q;
  logic        acc;
  logic        hit;
  logic [31:0] rd_mux;
  panel_pkg::menu_e menu_q;
  logic [3:0]  digit_q;

  assign acc = psel & penable & ~pready;
  assign hit = (paddr == `REG_CTRL) | (paddr == `REG_STAT) | (paddr == `REG_DISP);

  always_comb begin
    rd_mux = 32'h0;
    case (paddr)
      `REG_CTRL: rd_mux = {26'h0, ctrl_q};
      `REG_STAT: rd_mux = {16'h0, 3'h0, drive_fault, 3'h0, local_q, digit_q,
                           2'h0, menu_q};
      `REG_DISP: rd_mux = 32'(display_value);
      default:   rd_mux = 32'h0;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~hit;
      prdata  <= (acc & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `CTRL_RESET;
    end else if (psel & penable & pready & pwrite & (paddr == `REG_CTRL)) begin
      ctrl_q <= pwdata[5:0];
    end
  end

  logic [1:0] src_sel;
  logic [1:0] halt_cfg;
  logic [1:0] multi_cfg;
  logic [1:0] eff_src;
  assign src_sel   = ctrl_q[`CTRL_SRC_LSB +: 2];
  assign halt_cfg  = ctrl_q[`CTRL_HALT_LSB +: 2];
  assign multi_cfg = ctrl_q[`CTRL_MULTI_LSB +: 2];
  // local override from the multi key forces panel control
  assign eff_src   = local_q ? `SRC_PANEL : src_sel;

  // *************************************************************
  // key debounce
  // *************************************************************
  logic [`KEY_N-1:0] key_db_q;
  logic [`KEY_N-1:0] key_prev_q;
  logic [`KEY_N-1:0] press;

  for (genvar k = 0; k < `KEY_N; k++) begin : g_deb
    logic [31:0] cnt_q;
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        cnt_q       <= 32'h0;
        key_db_q[k] <= 1'b0;
      end else if (key_raw[k] == key_db_q[k]) begin
        cnt_q <= 32'h0;
      end else if (cnt_q == 32'(DEB_CYC - 1)) begin
        cnt_q       <= 32'h0;
        key_db_q[k] <= key_raw[k];
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      key_prev_q <= '0;
    end else begin
      key_prev_q <= key_db_q;
    end
  end

  assign press = key_db_q & ~key_prev_q;

  // *************************************************************
  // encoder knob
  // *************************************************************
  logic enc_a_q;
  logic knob_up;
  logic knob_dn;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enc_a_q <= 1'b0;
    end else begin
      enc_a_q <= enc_a;
    end
  end

  // on a rising a, b low means clockwise
  assign knob_up = enc_a & ~enc_a_q & ~enc_b;
  assign knob_dn = enc_a & ~enc_a_q & enc_b;

  logic step_up;
  logic step_dn;
  assign step_up = press[`KEY_INC] | knob_up;
  assign step_dn = press[`KEY_DEC] | knob_dn;

  // *************************************************************
  // menu navigation and editing
  // *************************************************************
  logic [DATA_W-1:0] edit_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      menu_q <= panel_pkg::MENU_MONITOR;
    end else begin
      case (menu_q)
        panel_pkg::MENU_MONITOR: begin
          if (press[`KEY_MENU]) menu_q <= panel_pkg::MENU_CODE;
        end
        panel_pkg::MENU_CODE: begin
          if (press[`KEY_MENU]) menu_q <= panel_pkg::MENU_MONITOR;
          else if (press[`KEY_ENTER]) menu_q <= panel_pkg::MENU_EDIT;
        end
        panel_pkg::MENU_EDIT: begin
          if (press[`KEY_MENU] | press[`KEY_ENTER]) menu_q <= panel_pkg::MENU_CODE;
        end
        default: menu_q <= panel_pkg::MENU_MONITOR;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      param_code <= '0;
    end else if (menu_q == panel_pkg::MENU_CODE) begin
      if (step_up) param_code <= param_code + CODE_W'(1);
      else if (step_dn) param_code <= param_code - CODE_W'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      edit_q <= '0;
    end else if (menu_q == panel_pkg::MENU_CODE && press[`KEY_ENTER]) begin
      edit_q <= param_value;
    end else if (menu_q == panel_pkg::MENU_EDIT) begin
      if (step_up) edit_q <= edit_q + digit_step(digit_q);
      else if (step_dn) edit_q <= edit_q - digit_step(digit_q);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      digit_q <= 4'h0;
    end else if (menu_q != panel_pkg::MENU_EDIT) begin
      digit_q <= 4'h0;
    end else if (press[`KEY_SHIFT]) begin
      digit_q <= (digit_q == 4'(DIGITS - 1)) ? 4'h0 : digit_q + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      monitor_sel <= `MON_SET_FREQ;
    end else if (menu_q == panel_pkg::MENU_MONITOR && press[`KEY_SHIFT]) begin
      monitor_sel <= (monitor_sel == 4'(MON_N - 1)) ? `MON_SET_FREQ
                                                    : monitor_sel + 4'h1;
    end
  end

  // commit on confirm at the deepest level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      param_wr      <= 1'b0;
      param_wr_data <= '0;
    end else begin
      param_wr <= (menu_q == panel_pkg::MENU_EDIT) & press[`KEY_ENTER];
      if ((menu_q == panel_pkg::MENU_EDIT) & press[`KEY_ENTER]) begin
        param_wr_data <= edit_q;
      end
    end
  end

  // outside the menus the knob and keys trim the set frequency
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      freq_up   <= 1'b0;
      freq_down <= 1'b0;
    end else begin
      freq_up   <= (menu_q == panel_pkg::MENU_MONITOR) & step_up;
      freq_down <= (menu_q == panel_pkg::MENU_MONITOR) & step_dn;
    end
  end

  // *************************************************************
  // drive commands
  // *************************************************************
  logic stop_ok;
  logic reset_ok;
  assign stop_ok  = (eff_src == `SRC_PANEL) | halt_cfg[`HALT_ANY_SRC];
  assign reset_ok = ~halt_cfg[`HALT_NO_RESET];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_cmd     <= 1'b0;
      stop_cmd    <= 1'b0;
      fault_reset <= 1'b0;
    end else begin
      run_cmd     <= press[`KEY_RUN] & (eff_src == `SRC_PANEL) & ~drive_fault;
      stop_cmd    <= press[`KEY_STOP] & ~drive_fault & drive_running & stop_ok;
      fault_reset <= press[`KEY_STOP] & drive_fault & reset_ok;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      local_q    <= 1'b0;
      dir_toggle <= 1'b0;
    end else begin
      dir_toggle <= press[`KEY_MULTI] & (multi_cfg == `MF_DIR);
      if (press[`KEY_MULTI] & (multi_cfg == `MF_LOCAL)) begin
        local_q <= ~local_q;
      end else if (multi_cfg != `MF_LOCAL) begin
        local_q <= 1'b0;
      end
    end
  end

  // *************************************************************
  // blink timebases
  // *************************************************************
  logic [31:0] slow_cnt_q;
  logic [31:0] fast_cnt_q;
  logic        slow_q;
  logic        fast_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slow_cnt_q <= 32'h0;
      slow_q     <= 1'b0;
    end else if (slow_cnt_q == 32'(SLOW_HALF - 1)) begin
      slow_cnt_q <= 32'h0;
      slow_q     <= ~slow_q;
    end else begin
      slow_cnt_q <= slow_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fast_cnt_q <= 32'h0;
      fast_q     <= 1'b0;
    end else if (fast_cnt_q == 32'(FAST_HALF - 1)) begin
      fast_cnt_q <= 32'h0;
      fast_q     <= ~fast_q;
    end else begin
      fast_cnt_q <= fast_cnt_q + 32'h1;
    end
  end

  // *************************************************************
  // lamps and display
  // *************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_lamp                 <= 1'b0;
      direction_lamp           <= 1'b0;
      source_lamp              <= 1'b0;
      tuning_torque_fault_lamp <= 1'b0;
    end else begin
      run_lamp       <= drive_running;
      direction_lamp <= drive_reverse;
      case (eff_src)
        `SRC_PANEL: source_lamp <= 1'b0;
        `SRC_TERM:  source_lamp <= 1'b1;
        `SRC_COMM:  source_lamp <= slow_q;
        default:    source_lamp <= 1'b0;
      endcase
      if (drive_fault) tuning_torque_fault_lamp <= fast_q;
      else if (drive_tuning) tuning_torque_fault_lamp <= slow_q;
      else tuning_torque_fault_lamp <= drive_torque_mode;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      display_value <= '0;
    end else if (drive_fault && menu_q == panel_pkg::MENU_MONITOR) begin
      display_value <= fault_code;
    end else begin
      case (menu_q)
        panel_pkg::MENU_CODE: display_value <= DATA_W'(param_code);
        panel_pkg::MENU_EDIT: display_value <= edit_q;
        default: begin
          if (monitor_sel == `MON_SET_FREQ) display_value <= set_freq;
          else if (monitor_sel == `MON_OUT_FREQ) display_value <= out_freq;
          else display_value <= monitor_value;
        end
      endcase
    end
  end

endmodule : operator_panel_controller
`default_nettype wire

// File: src/panel_cfg.svh
// constants for the operator panel controller
`ifndef PANEL_CFG_SVH
`define PANEL_CFG_SVH

// key positions in the raw key vector
`define KEY_MENU       0
`define KEY_ENTER      1
`define KEY_MULTI      2
`define KEY_SHIFT      3
`define KEY_INC        4
`define KEY_DEC        5
`define KEY_RUN        6
`define KEY_STOP       7
`define KEY_N          8

// apb byte offsets
`define REG_CTRL       8'h00
`define REG_STAT       8'h04
`define REG_DISP       8'h08

// control register fields
`define CTRL_SRC_LSB   0
`define CTRL_HALT_LSB  2
`define CTRL_MULTI_LSB 4
`define CTRL_RESET     6'h00

// command source codes
`define SRC_PANEL      2'h0
`define SRC_TERM       2'h1
`define SRC_COMM       2'h2

// halt key config bits
`define HALT_ANY_SRC   0
`define HALT_NO_RESET  1

// multi-function key actions
`define MF_NONE        2'h0
`define MF_DIR         2'h1
`define MF_LOCAL       2'h2

// monitor display slots
`define MON_SET_FREQ   4'h0
`define MON_OUT_FREQ   4'h1

// timing
`define CLK_HZ         250000000
`define SLOW_BLINK_HZ  1
`define FAST_BLINK_HZ  4
`define DEBOUNCE_MS    10

`endif

// File: src/panel_pkg.sv
// types for the operator panel controller
package panel_pkg;

  typedef enum logic [1:0] {
    MENU_MONITOR,
    MENU_CODE,
    MENU_EDIT
  } menu_e;

endpackage : panel_pkg

// File: test/operator_model.sv
// operator model: presses one key, holds it, releases it
`timescale 1ns/100ps
`default_nettype none
`include "panel_cfg.svh"
module operator_model #(
  parameter int HOLD = 8
) (
  input  wire logic              clk,
  input  wire logic              go,
  input  wire logic [2:0]        key_idx,
  output var  logic [`KEY_N-1:0] key_raw,
  output var  logic              busy
);
  int cnt;
  initial begin
    key_raw = '0;
    busy = 1'b0;
  end
  always @(posedge clk) begin
    if (go && !busy) begin
      key_raw[key_idx] <= 1'b1;
      busy <= 1'b1;
      cnt <= 2 * HOLD;
    end else if (busy) begin
      cnt <= cnt - 1;
      if (cnt == HOLD) key_raw <= '0;
      if (cnt == 1) busy <= 1'b0;
    end
  end
endmodule : operator_model
`default_nettype wire

// File: test/panel_checker.sv
// assertion checker for the operator panel controller
`timescale 1ns/100ps
`default_nettype none
`include "panel_cfg.svh"
module panel_checker #(
  parameter int SLOW_HALF = 16,
  parameter int FAST_HALF = 4
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [7:0]  key_raw,
  input wire logic        drive_running,
  input wire logic        drive_reverse,
  input wire logic        drive_fault,
  input wire logic        run_lamp,
  input wire logic        direction_lamp,
  input wire logic        source_lamp,
  input wire logic        tuning_torque_fault_lamp,
  input wire logic        run_cmd,
  input wire logic        stop_cmd,
  input wire logic        fault_reset,
  input wire logic        param_wr
);
  logic [1:0] src_q;
  logic [1:0] halt_q;
  logic [1:0] mf_q;
  int         src_stab_q;
  int         ttf_stab_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ****************************************
  // snooped control settings
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      src_q  <= 2'h0;
      halt_q <= 2'h0;
      mf_q   <= 2'h0;
    end else if (psel && penable && pready && pwrite && paddr == `REG_CTRL) begin
      src_q  <= pwdata[1:0];
      halt_q <= pwdata[3:2];
      mf_q   <= pwdata[5:4];
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) src_stab_q <= 0;
    else if (src_q != `SRC_COMM || $changed(source_lamp)) src_stab_q <= 0;
    else src_stab_q <= src_stab_q + 1;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ttf_stab_q <= 0;
    else if (!drive_fault || $changed(tuning_torque_fault_lamp)) ttf_stab_q <= 0;
    else ttf_stab_q <= ttf_stab_q + 1;
  end
  // ****************************************
  // assertions
  // ****************************************
  AST_RUN_LAMP: assert property ($stable(drive_running) |-> run_lamp == drive_running)
    else $error("run lamp does not follow drive state");
  AST_DIR_LAMP: assert property ($stable(drive_reverse) |-> direction_lamp == drive_reverse)
    else $error("direction lamp does not follow rotation");
  AST_SRC_PANEL: assert property (src_q == `SRC_PANEL |=> !source_lamp)
    else $error("source lamp lit for panel source");
  AST_SRC_TERM: assert property (src_q == `SRC_TERM && mf_q != `MF_LOCAL |=> source_lamp)
    else $error("source lamp dark for terminal source");
  AST_SRC_BLINK: assert property (src_stab_q < SLOW_HALF + 3)
    else $error("source lamp not blinking for link source");
  AST_FAULT_BLINK: assert property (ttf_stab_q < FAST_HALF + 3)
    else $error("fault lamp not blinking fast");
  AST_RUN_GATE: assert property (run_cmd |->
    ((src_q == `SRC_PANEL || mf_q == `MF_LOCAL) && !drive_fault) ##1 !run_cmd)
    else $error("run pulse from wrong source or too long");
  AST_STOP_GATE: assert property (stop_cmd |-> drive_running &&
    (src_q == `SRC_PANEL || halt_q[0] || mf_q == `MF_LOCAL))
    else $error("stop pulse without running drive");
  AST_RESET_GATE: assert property (fault_reset |-> (drive_fault && !halt_q[1]) ##1 !fault_reset)
    else $error("fault reset without fault or when disabled");
  AST_DEBOUNCE: assert property ($rose(run_cmd) |-> $past(key_raw[`KEY_RUN], 3))
    else $error("run pulse without a held key");
  AST_APB_WAIT: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("apb wait state wrong");
  COV_RUN: cover property (run_cmd);
  COV_RESET: cover property (fault_reset);
  COV_WRITE: cover property (param_wr);
endmodule : panel_checker
bind operator_panel_controller panel_checker #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) chk (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .key_raw(key_raw),
  .drive_running(drive_running), .drive_reverse(drive_reverse), .drive_fault(drive_fault),
  .run_lamp(run_lamp), .direction_lamp(direction_lamp), .source_lamp(source_lamp),
  .tuning_torque_fault_lamp(tuning_torque_fault_lamp), .run_cmd(run_cmd),
  .stop_cmd(stop_cmd), .fault_reset(fault_reset), .param_wr(param_wr));
`default_nettype wire

// File: test/test_operator_panel_controller.sv
// self-checking bench for the operator panel controller
`timescale 1ns/100ps
`default_nettype none
`include "panel_cfg.svh"
module test_operator_panel_controller;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, enc_a = 0, enc_b = 0;
  logic [7:0] paddr = 0, key_raw;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic pready, pslverr, rerr, go = 0, busy;
  logic [2:0] key_idx = 0;
  logic run_r = 0, rev_r = 0, torq_r = 0, tune_r = 0, flt_r = 0;
  logic [15:0] dval, pwd, wr_d;
  logic [15:0] sfq = 16'h0A5A, ofq = 16'h1B2C, mvl = 16'h3C4D, fcd = 16'h00E7, pvl = 16'h1234;
  logic [7:0] pcode;
  logic [3:0] msel;
  logic l_run, l_dir, l_src, l_ttf, pwr, c_run, c_stop, c_rst, c_up, c_dn, c_dir, clr = 0;
  int n[7], errors = 0, total_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  operator_model #(.HOLD(8)) op (.clk(clk), .go(go), .key_idx(key_idx), .key_raw(key_raw),
    .busy(busy));
  operator_panel_controller #(.SLOW_HALF(16), .FAST_HALF(4), .DEB_CYC(3)) uut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_raw(key_raw), .enc_a(enc_a), .enc_b(enc_b), .drive_running(run_r),
    .drive_reverse(rev_r), .drive_torque_mode(torq_r), .drive_tuning(tune_r),
    .drive_fault(flt_r), .set_freq(sfq), .out_freq(ofq), .monitor_value(mvl),
    .fault_code(fcd), .param_value(pvl), .display_value(dval), .monitor_sel(msel),
    .run_lamp(l_run), .direction_lamp(l_dir), .source_lamp(l_src),
    .tuning_torque_fault_lamp(l_ttf), .param_code(pcode), .param_wr_data(pwd), .param_wr(pwr),
    .run_cmd(c_run), .stop_cmd(c_stop), .fault_reset(c_rst), .freq_up(c_up),
    .freq_down(c_dn), .dir_toggle(c_dir));
  // ****************************************
  // pulse counters and timeout
  // ****************************************
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
    if (pwr === 1'b1) wr_d = pwd;
    if (clr) n = '{default: 0};
    else n = '{n[0] + c_run, n[1] + c_stop, n[2] + c_rst, n[3] + c_up, n[4] + c_dn,
      n[5] + c_dir, n[6] + pwr};
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 0);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic press(input int k, input int times = 1);
    repeat (times) begin
      @(posedge clk);
      key_idx <= k[2:0];
      go <= 1;
      @(posedge clk);
      go <= 0;
      do @(posedge clk); while (busy);
    end
  endtask : press
  task automatic clear();
    @(posedge clk);
    clr <= 1;
    @(posedge clk);
    clr <= 0;
  endtask : clear
  task automatic toggles(input bit ttf, output int t);
    logic last;
    t = 0;
    last = ttf ? l_ttf : l_src;
    repeat (64) begin
      @(posedge clk);
      if ((ttf ? l_ttf : l_src) !== last) t++;
      last = ttf ? l_ttf : l_src;
    end
  endtask : toggles
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    apb(0, `REG_CTRL);
    check(rdat, 0);
    apb(1, `REG_CTRL, 32'hFFFFFFFF);
    apb(0, `REG_CTRL);
    check(rdat, 32'h0000003F);
    apb(1, 8'h0C, 32'h00000001);
    check(rerr, 1);
    apb(0, 8'h0C);
    check({rdat, rerr}, 33'h1);
    apb(1, `REG_CTRL, 0);
  endtask : t_regs
  task automatic t_lamps();
    int ns, nf;
    run_r <= 1;
    rev_r <= 1;
    repeat (3) @(posedge clk);
    check({l_run, l_dir}, 2'h3);
    run_r <= 0;
    rev_r <= 0;
    apb(1, `REG_CTRL, `SRC_TERM);
    repeat (3) @(posedge clk);
    check({l_run, l_dir, l_src}, 3'h1);
    apb(1, `REG_CTRL, `SRC_COMM);
    toggles(0, ns);
    check(ns >= 3, 1);
    apb(1, `REG_CTRL, `SRC_PANEL);
    repeat (3) @(posedge clk);
    check(l_src, 0);
    torq_r <= 1;
    repeat (3) @(posedge clk);
    toggles(1, ns);
    check({ns[3:0], l_ttf}, 5'h01);
    tune_r <= 1;
    toggles(1, ns);
    flt_r <= 1;
    toggles(1, nf);
    check(ns >= 3 && nf >= 2 * ns, 1);
    {torq_r, tune_r, flt_r} <= 0;
  endtask : t_lamps
  task automatic t_cmds();
    clear();
    press(`KEY_RUN);
    apb(1, `REG_CTRL, `SRC_TERM);
    press(`KEY_RUN);
    check(n[0], 1);
    run_r <= 1;
    press(`KEY_STOP);
    check(n[1], 0);
    apb(1, `REG_CTRL, 32'h00000010);
    press(`KEY_STOP);
    press(`KEY_MULTI);
    check({n[1], n[5]}, 64'h100000001);
    run_r <= 0;
    flt_r <= 1;
    press(`KEY_STOP);
    check({n[1], n[2]}, 64'h100000001);
    apb(1, `REG_CTRL, 32'h00000008);
    press(`KEY_STOP);
    check(n[2], 1);
    apb(1, `REG_CTRL, 0);
    repeat (3) @(posedge clk);
    check(dval, 16'h00E7);
    flt_r <= 0;
  endtask : t_cmds
  task automatic t_monitor();
    clear();
    press(`KEY_SHIFT);
    repeat (3) @(posedge clk);
    check({msel, dval}, 20'h11B2C);
    press(`KEY_SHIFT, 7);
    repeat (3) @(posedge clk);
    check({msel, dval}, 20'h00A5A);
    press(`KEY_INC);
    press(`KEY_DEC, 2);
    @(posedge clk) enc_a <= 1;
    @(posedge clk) enc_a <= 0;
    enc_b <= 1;
    @(posedge clk) enc_a <= 1;
    repeat (4) @(posedge clk);
    check({n[3], n[4]}, 64'h200000003);
    press(`KEY_SHIFT, 2);
    repeat (3) @(posedge clk);
    check({msel, dval}, 20'h23C4D);
  endtask : t_monitor
  task automatic t_menu();
    clear();
    press(`KEY_MENU);
    apb(0, `REG_STAT);
    check(rdat[1:0], 1);
    press(`KEY_INC);
    check(pcode, 8'h01);
    press(`KEY_ENTER);
    press(`KEY_SHIFT);
    apb(0, `REG_STAT);
    check(rdat[7:0], 8'h12);
    press(`KEY_INC);
    apb(0, `REG_DISP);
    check(rdat, 32'h00001244);
    press(`KEY_ENTER);
    apb(0, `REG_STAT);
    check({n[6], wr_d, rdat[1:0]}, 50'h44911);
    press(`KEY_MENU);
    apb(0, `REG_STAT);
    check(rdat[1:0], 0);
  endtask : t_menu
  task automatic t_local();
    clear();
    apb(1, `REG_CTRL, 32'h00000021);
    press(`KEY_MULTI);
    apb(0, `REG_STAT);
    check({rdat[8], l_src}, 2'h2);
    press(`KEY_RUN);
    check(n[0], 1);
    apb(1, `REG_CTRL, 0);
  endtask : t_local
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1;
    repeat (8) @(posedge clk);
    t_regs();
    t_lamps();
    t_cmds();
    t_monitor();
    t_menu();
    t_local();
    wrap_up();
  end
endmodule : test_operator_panel_controller
`default_nettype wire
